// ==== rtl/state_trigger_sequencer_defines.svh ====
// constants of the state trigger sequencer: config word map, limits, timing
// assumes a 100 MHz sample clock and a 32-bit configuration word port
`ifndef STATE_TRIGGER_SEQUENCER_DEFINES_SVH
`define STATE_TRIGGER_SEQUENCER_DEFINES_SVH
`define CFG_WORDS 512
`define PAT_BASE 9'h000
`define RNG_BASE 9'h030
`define TMR_BASE 9'h05A
`define GCT_BASE 9'h05E
`define EDG_BASE 9'h064
`define GST_BASE 9'h067
`define LVL_BASE 9'h06A
`define LVL_WORDS 9'h016
`define LVL_OCC 9'h010
`define LVL_STORE 9'h013
`define OFS_BASE 9'h1D0
`define N_LVL 16
`define N_PAT 16
`define N_PAT_FAST 14
`define N_RNG 14
`define N_RNG_FAST 7
`define N_TMR 2
`define N_GCT 2
`define N_FLG 4
`define N_EDG 3
`define N_BR 4
`define N_BR_FAST 2
`define RES_W 42
`define R_RNG 16
`define R_TMR 30
`define R_GCT 32
`define R_OCC 34
`define R_FLG 35
`define R_EDG 39
`define A_GOTO_EN 4
`define A_TRIG 5
`define A_STORE 6
`define A_DSTORE 8
`define A_TMR 10
`define A_GCT 16
`define A_OCC_RST 20
`define A_FLG 21
`define A_EN 31
`define H_OVR 30
`define CNT_W 81
`define CNT_MAX 81'd2000000000000000000000000
`define SEQ_MAX_MHZ_300 300
`define SEQ_MAX_MHZ_600 600
`define CLK_PERIOD_PS 10000
`define TMR_RES_PS 2000
`define TMR_MIN_NS 40
`define TMR_MAX_S 2199
`define TMR_W 41
`define TMR_TICK (41'(`CLK_PERIOD_PS / `TMR_RES_PS))
`define TMR_MIN_UNITS (41'(`TMR_MIN_NS * 1000 / `TMR_RES_PS))
`define TMR_MAX_UNITS (41'(64'(`TMR_MAX_S) * 64'd1000000000000 \
    / 64'(`TMR_RES_PS)))
`endif

// ==== rtl/state_trigger_sequencer_pkg.sv ====
// types of the state trigger sequencer
// assumes nothing beyond the defines header
package state_trigger_sequencer_pkg;
    typedef enum logic [1:0] {
        ACQ_IDLE = 2'b00,
        ACQ_RUN = 2'b01,
        ACQ_POST = 2'b10,
        ACQ_DONE = 2'b11
    } acq_state_t;
    typedef enum logic [1:0] {
        POS_START = 2'b00,
        POS_CENTRE = 2'b01,
        POS_END = 2'b10,
        POS_USER = 2'b11
    } trig_pos_t;
    typedef enum logic [2:0] {
        TMR_NONE = 3'b000,
        TMR_START = 3'b001,
        TMR_STOP = 3'b010,
        TMR_PAUSE = 3'b011,
        TMR_RESUME = 3'b100
    } tmr_act_t;
endpackage : state_trigger_sequencer_pkg

// ==== rtl/state_trigger_sequencer.sv ====
// trigger sequencer and store qualifier for a state acquisition channel set
// assumes clk_in is the probed system clock; config is written word-wise
// Functional notes
// - sixteen ordered sequence levels, each with its own branch conditions
// - four prioritised branches per level; two in the 600 Mb/s mode
// - sixteen pattern recognisers with six comparison operators
// - fourteen range recognisers, in-range or not-in-range selectable
// - 600 Mb/s mode: fourteen patterns and seven ranges only
// - two timers and two global counters, absent in 600 Mb/s mode
// - one occurrence counter per level in both modes; four settable flags outside 600 Mb/s mode
// - branch conditions are Boolean terms over all resource outputs
// - full action set: goto, trigger, store, timers, counters, flags
// - 600 Mb/s mode actions are only goto or trigger-and-fill
// - global store default, per-level override outside 600 Mb/s mode
// - occurrence and global counters reach 2E+24 and saturate there
// - recognisers compare a field of at most 32 bits
// - timers span 40 ns to 2199 s with 2 ns granularity
// - one sample evaluated per clock step
// - trigger at start, centre, end or user position sets post count
// - 600 Mb/s state mode allows only one analyzer to run
// - tags on with all pods assigned halve usable depth
// - per-channel sample offset before, at or after the clock edge
// - timing mode keeps sixteen levels, four branches, adds edge detectors
`timescale 1ns/1ps
`include "state_trigger_sequencer_defines.svh"

module state_trigger_sequencer
    import state_trigger_sequencer_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [31:0] sample_in,
    input wire logic [3:0] qual_in,
    input wire logic [3:0] qual_sel_in,
    input wire logic cfg_we_in,
    input wire logic [8:0] cfg_addr_in,
    input wire logic [31:0] cfg_data_in,
    input wire logic fast_mode_in,
    input wire logic timing_mode_in,
    input wire logic arm_in,
    input wire logic [1:0] trig_pos_in,
    input wire logic [31:0] user_post_in,
    input wire logic [31:0] mem_depth_in,
    input wire logic tags_en_in,
    input wire logic all_pods_in,
    input wire logic analyzer2_req_in,
    output logic store_out,
    output logic [31:0] store_data_out,
    output logic trigger_out,
    output logic triggered_out,
    output logic done_out,
    output logic [3:0] level_out,
    output logic [3:0] flags_out,
    output logic analyzer2_run_out,
    output logic [31:0] depth_out
);
    logic [31:0] cfg_mem [0:`CFG_WORDS-1];
    logic [31:0] sync1_reg, sync2_reg, prev_reg, samp;
    logic [31:0] dl_reg [1:4];
    logic [3:0] qsync1_reg, qsync2_reg, qd1_reg, qd2_reg;
    logic [`RES_W-1:0] res;
    logic [`CNT_W-1:0] occ_reg [0:`N_LVL-1];
    logic [`CNT_W-1:0] gct_reg [0:`N_GCT-1];
    logic [`TMR_W-1:0] tmr_reg [0:`N_TMR-1];
    logic [`N_TMR-1:0] tmr_run_reg;
    logic [3:0] level_reg, flg_reg;
    logic dstore_reg, trig_reg, done_reg, trig_pulse_reg;
    logic [31:0] post_reg, post_tgt, depth_reg;
    acq_state_t state_reg;
    logic lim, step, hit, store_q, store_now;
    logic [31:0] act;
    logic [8:0] lb;

    function automatic logic term_hit(input logic [`RES_W-1:0] r,
        input logic [31:0] c, input logic [31:0] w, input logic [31:0] h);
        logic [`RES_W-1:0] care;
        logic [`RES_W-1:0] want;
        care = {h[9:0], c};
        want = {h[25:16], w};
        term_hit = ((((r ^ want) & care) == '0) ^ h[31]);
    endfunction : term_hit

    // the reduced mode applies to the fast state mode only
    assign lim = fast_mode_in & ~timing_mode_in;
    assign lb = `LVL_BASE + 9'(level_reg) * `LVL_WORDS;
    // one sample per clock, gated by the selected qualifiers
    assign step = ((state_reg == ACQ_RUN) || (state_reg == ACQ_POST))
        & (&(qd2_reg | ~qual_sel_in));

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            for (int i = 0; i < `CFG_WORDS; i++) begin
                cfg_mem[i] <= 32'h0;
            end
        end else if (cfg_we_in) begin
            cfg_mem[cfg_addr_in] <= cfg_data_in;
        end
    end

    // pin synchronisers and the offset delay line; tap 2 is the edge
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sync1_reg <= 32'h0;
            sync2_reg <= 32'h0;
            qsync1_reg <= 4'h0;
            qsync2_reg <= 4'h0;
            qd1_reg <= 4'h0;
            qd2_reg <= 4'h0;
            prev_reg <= 32'h0;
            for (int k = 1; k <= 4; k++) begin
                dl_reg[k] <= 32'h0;
            end
        end else begin
            sync1_reg <= sample_in;
            sync2_reg <= sync1_reg;
            qsync1_reg <= qual_in;
            qsync2_reg <= qsync1_reg;
            qd1_reg <= qsync2_reg;
            qd2_reg <= qd1_reg;
            prev_reg <= samp;
            dl_reg[1] <= sync2_reg;
            for (int k = 2; k <= 4; k++) begin
                dl_reg[k] <= dl_reg[k-1];
            end
        end
    end

    // signed two-bit offset per channel: -2,-1 earlier, 0 on edge, +1 later
    always_comb begin
        logic [63:0] ofs;
        ofs = {cfg_mem[`OFS_BASE+1], cfg_mem[`OFS_BASE]};
        samp = 32'h0;
        for (int ch = 0; ch < 32; ch++) begin
            case (ofs[2*ch+:2])
                2'h0: samp[ch] = dl_reg[2][ch];
                2'h1: samp[ch] = dl_reg[1][ch];
                2'h2: samp[ch] = dl_reg[4][ch];
                default: samp[ch] = dl_reg[3][ch];
            endcase
        end
    end

    always_comb begin
        logic [31:0] m;
        logic [31:0] a;
        logic [31:0] v;
        logic [`TMR_W-1:0] tl;
        m = 32'h0;
        a = 32'h0;
        v = 32'h0;
        tl = '0;
        res = '0;
        for (int i = 0; i < `N_PAT; i++) begin
            m = cfg_mem[`PAT_BASE+3*i+1];
            a = samp & m;
            v = cfg_mem[`PAT_BASE+3*i] & m;
            if (i < (lim ? `N_PAT_FAST : `N_PAT)) begin
                case (cfg_mem[`PAT_BASE+3*i+2][2:0])
                    3'h0: res[i] = (a == v);
                    3'h1: res[i] = (a != v);
                    3'h2: res[i] = (a > v);
                    3'h3: res[i] = (a >= v);
                    3'h4: res[i] = (a < v);
                    3'h5: res[i] = (a <= v);
                    default: res[i] = 1'b0;
                endcase
            end
        end
        for (int i = 0; i < `N_RNG; i++) begin
            if (i < (lim ? `N_RNG_FAST : `N_RNG)) begin
                res[`R_RNG+i] = ((samp >= cfg_mem[`RNG_BASE+3*i])
                    && (samp <= cfg_mem[`RNG_BASE+3*i+1]))
                    ^ cfg_mem[`RNG_BASE+3*i+2][0];
            end
        end
        for (int i = 0; i < `N_TMR; i++) begin
            tl = {cfg_mem[`TMR_BASE+2*i+1][8:0], cfg_mem[`TMR_BASE+2*i]};
            if (tl < `TMR_MIN_UNITS) begin
                tl = `TMR_MIN_UNITS;
            end else if (tl > `TMR_MAX_UNITS) begin
                tl = `TMR_MAX_UNITS;
            end
            res[`R_TMR+i] = ~lim & (tmr_reg[i] >= tl);
        end
        for (int i = 0; i < `N_GCT; i++) begin
            res[`R_GCT+i] = ~lim & (gct_reg[i] >=
                {cfg_mem[`GCT_BASE+3*i+2][16:0],
                cfg_mem[`GCT_BASE+3*i+1], cfg_mem[`GCT_BASE+3*i]});
        end
        res[`R_OCC] = occ_reg[level_reg] >= {cfg_mem[lb+`LVL_OCC+2][16:0],
            cfg_mem[lb+`LVL_OCC+1], cfg_mem[lb+`LVL_OCC]};
        res[`R_FLG+:`N_FLG] = flg_reg;
        for (int i = 0; i < `N_EDG; i++) begin
            res[`R_EDG+i] = timing_mode_in
                & (|((samp ^ prev_reg) & cfg_mem[`EDG_BASE+i]));
        end
    end

    // lowest enabled branch that hits wins
    always_comb begin
        hit = 1'b0;
        act = 32'h0;
        for (int b = `N_BR - 1; b >= 0; b--) begin
            if ((b < (lim ? `N_BR_FAST : `N_BR))
                && cfg_mem[lb+4*b+3][`A_EN]
                && term_hit(res, cfg_mem[lb+4*b], cfg_mem[lb+4*b+1],
                    cfg_mem[lb+4*b+2])) begin
                hit = 1'b1;
                act = cfg_mem[lb+4*b+3];
            end
        end
        if (lim) begin
            act = act & 32'h0000003F;
            if (act[`A_TRIG]) begin
                act[`A_GOTO_EN] = 1'b0;
            end
        end
    end

    always_comb begin
        if (!lim && cfg_mem[lb+`LVL_STORE+2][`H_OVR]) begin
            store_q = term_hit(res, cfg_mem[lb+`LVL_STORE],
                cfg_mem[lb+`LVL_STORE+1], cfg_mem[lb+`LVL_STORE+2]);
        end else begin
            store_q = dstore_reg & term_hit(res, cfg_mem[`GST_BASE],
                cfg_mem[`GST_BASE+1], cfg_mem[`GST_BASE+2]);
        end
        if (hit && !lim && act[`A_STORE+:2] == 2'h1) begin
            store_q = 1'b1;
        end else if (hit && !lim && act[`A_STORE+:2] == 2'h2) begin
            store_q = 1'b0;
        end
        store_now = step & store_q;
    end

    always_comb begin
        unique case (trig_pos_in)
            POS_START: post_tgt = depth_reg - 32'h1;
            POS_CENTRE: post_tgt = depth_reg >> 1;
            POS_END: post_tgt = 32'h0;
            POS_USER: post_tgt = (user_post_in < depth_reg) ? user_post_in
                : depth_reg - 32'h1;
        endcase
    end

    // acquisition sequence: arm, one trigger, post-trigger fill
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_reg <= ACQ_IDLE;
            trig_reg <= 1'b0;
            trig_pulse_reg <= 1'b0;
            done_reg <= 1'b0;
            post_reg <= 32'h0;
        end else begin
            trig_pulse_reg <= 1'b0;
            if (arm_in) begin
                state_reg <= ACQ_RUN;
                trig_reg <= 1'b0;
                done_reg <= 1'b0;
            end else begin
                unique case (state_reg)
                    ACQ_IDLE, ACQ_DONE: ;
                    ACQ_RUN: begin
                        if (step && hit && act[`A_TRIG] && !trig_reg) begin
                            trig_reg <= 1'b1;
                            trig_pulse_reg <= 1'b1;
                            post_reg <= post_tgt;
                            if (post_tgt == 32'h0) begin
                                state_reg <= ACQ_DONE;
                                done_reg <= 1'b1;
                            end else begin
                                state_reg <= ACQ_POST;
                            end
                        end
                    end
                    ACQ_POST: begin
                        if (store_now && post_reg <= 32'h1) begin
                            state_reg <= ACQ_DONE;
                            done_reg <= 1'b1;
                        end else if (store_now) begin
                            post_reg <= post_reg - 32'h1;
                        end
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            level_reg <= 4'h0;
        end else if (arm_in) begin
            level_reg <= 4'h0;
        end else if (step && hit && act[`A_GOTO_EN]) begin
            level_reg <= act[3:0];
        end
    end

    // occurrence count: qualified samples spent at each level
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            for (int l = 0; l < `N_LVL; l++) begin
                occ_reg[l] <= '0;
            end
        end else if (arm_in) begin
            for (int l = 0; l < `N_LVL; l++) begin
                occ_reg[l] <= '0;
            end
        end else if (step && hit && !lim && act[`A_OCC_RST]) begin
            occ_reg[level_reg] <= '0;
        end else if (step && occ_reg[level_reg] < `CNT_MAX) begin
            occ_reg[level_reg] <= occ_reg[level_reg] + `CNT_W'(1);
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            for (int i = 0; i < `N_GCT; i++) begin
                gct_reg[i] <= '0;
            end
        end else begin
            for (int i = 0; i < `N_GCT; i++) begin
                if (arm_in) begin
                    gct_reg[i] <= '0;
                end else if (step && hit && !lim) begin
                    case (act[`A_GCT+2*i+:2])
                        2'h1: if (gct_reg[i] < `CNT_MAX) begin
                            gct_reg[i] <= gct_reg[i] + `CNT_W'(1);
                        end
                        2'h2: if (gct_reg[i] != '0) begin
                            gct_reg[i] <= gct_reg[i] - `CNT_W'(1);
                        end
                        2'h3: gct_reg[i] <= '0;
                        default: ;
                    endcase
                end
            end
        end
    end

    // timers advance five 2 ns units (10 ns) on every clock while running
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tmr_run_reg <= '0;
            for (int i = 0; i < `N_TMR; i++) begin
                tmr_reg[i] <= '0;
            end
        end else begin
            for (int i = 0; i < `N_TMR; i++) begin
                if (arm_in || lim) begin
                    tmr_run_reg[i] <= 1'b0;
                    tmr_reg[i] <= '0;
                end else if (step && hit
                    && act[`A_TMR+3*i+:3] != TMR_NONE) begin
                    case (tmr_act_t'(act[`A_TMR+3*i+:3]))
                        TMR_START: begin
                            tmr_run_reg[i] <= 1'b1;
                            tmr_reg[i] <= '0;
                        end
                        TMR_STOP: begin
                            tmr_run_reg[i] <= 1'b0;
                            tmr_reg[i] <= '0;
                        end
                        TMR_PAUSE: tmr_run_reg[i] <= 1'b0;
                        TMR_RESUME: tmr_run_reg[i] <= 1'b1;
                        default: ;
                    endcase
                end else if (tmr_run_reg[i]) begin
                    tmr_reg[i] <= (tmr_reg[i] + `TMR_TICK > `TMR_MAX_UNITS)
                        ? `TMR_MAX_UNITS : tmr_reg[i] + `TMR_TICK;
                end
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            flg_reg <= 4'h0;
            dstore_reg <= 1'b1;
        end else if (arm_in) begin
            flg_reg <= 4'h0;
            dstore_reg <= 1'b1;
        end else if (step && hit && !lim) begin
            for (int i = 0; i < `N_FLG; i++) begin
                if (act[`A_FLG+2*i+:2] == 2'h1) begin
                    flg_reg[i] <= 1'b1;
                end else if (act[`A_FLG+2*i+:2] == 2'h2) begin
                    flg_reg[i] <= 1'b0;
                end
            end
            if (act[`A_DSTORE+:2] == 2'h1) begin
                dstore_reg <= 1'b1;
            end else if (act[`A_DSTORE+:2] == 2'h2) begin
                dstore_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            store_out <= 1'b0;
            store_data_out <= 32'h0;
            analyzer2_run_out <= 1'b0;
            depth_reg <= 32'h0;
        end else begin
            store_out <= store_now;
            store_data_out <= samp;
            analyzer2_run_out <= analyzer2_req_in & ~lim;
            depth_reg <= (tags_en_in && all_pods_in) ? mem_depth_in >> 1
                : mem_depth_in;
        end
    end

    assign trigger_out = trig_pulse_reg;
    assign triggered_out = trig_reg;
    assign done_out = done_reg;
    assign level_out = level_reg;
    assign flags_out = flg_reg;
    assign depth_out = depth_reg;
endmodule : state_trigger_sequencer

// ==== test/state_trigger_sequencer_asserts.sv ====
// port checker of the trigger sequencer, bound to its top module
// assumes channel offsets stay zero and one clock domain
`timescale 1ns/1ps
module state_trigger_sequencer_asserts
    import state_trigger_sequencer_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [31:0] sample_in,
    input wire logic [3:0] qual_in,
    input wire logic [3:0] qual_sel_in,
    input wire logic fast_mode_in,
    input wire logic timing_mode_in,
    input wire logic arm_in,
    input wire logic [31:0] mem_depth_in,
    input wire logic tags_en_in,
    input wire logic all_pods_in,
    input wire logic analyzer2_req_in,
    input wire logic store_out,
    input wire logic [31:0] store_data_out,
    input wire logic trigger_out,
    input wire logic triggered_out,
    input wire logic done_out,
    input wire logic [3:0] level_out,
    input wire logic [3:0] flags_out,
    input wire logic analyzer2_run_out,
    input wire logic [31:0] depth_out
);
    logic q_ok;
    logic reduced;
    assign q_ok = (qual_in & qual_sel_in) == qual_sel_in;
    assign reduced = fast_mode_in && !timing_mode_in;
    default clocking dflt @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);
    sequence pulse_s;
        trigger_out ##1 !trigger_out;
    endsequence
    sequence cleared_s;
        level_out == 4'h0 && flags_out == 4'h0 && !triggered_out && !done_out;
    endsequence
    a_trig_pulse: assert property (trigger_out |-> pulse_s)
        else $error("trigger pulse longer than one cycle");
    a_trig_once: assert property (
        triggered_out && !arm_in |=> !trigger_out)
        else $error("second trigger in one acquisition");
    a_trig_flag: assert property (trigger_out |-> ##[0:1] triggered_out)
        else $error("triggered level missing after trigger");
    a_arm_clears: assert property (arm_in |=> cleared_s)
        else $error("arm did not clear level and flags");
    a_done_trig: assert property ($rose(done_out) |-> triggered_out)
        else $error("done without trigger");
    a_fast_hold: assert property (
        trigger_out && reduced |-> $stable(level_out))
        else $error("reduced mode moved level on trigger");
    a_level_qual: assert property (
        $changed(level_out) && !$past(arm_in) |-> $past(q_ok, 5))
        else $error("level moved on an unqualified sample");
    a_store_data: assert property (
        store_out |-> store_data_out == $past(sample_in, 5))
        else $error("stored data is not the zero offset sample");
    a_an2_follow: assert property (
        1'b1 |=> analyzer2_run_out == $past(analyzer2_req_in && !reduced))
        else $error("second analyzer run flag wrong");
    a_depth_half: assert property (1'b1 |=> depth_out ==
        $past(tags_en_in && all_pods_in ? mem_depth_in >> 1 : mem_depth_in))
        else $error("usable depth wrong");
endmodule : state_trigger_sequencer_asserts

bind state_trigger_sequencer state_trigger_sequencer_asserts u_chk (
    .clk_in, .rst_n_in, .sample_in, .qual_in, .qual_sel_in, .fast_mode_in,
    .timing_mode_in, .arm_in, .mem_depth_in, .tags_en_in, .all_pods_in,
    .analyzer2_req_in, .store_out, .store_data_out, .trigger_out,
    .triggered_out, .done_out, .level_out, .flags_out, .analyzer2_run_out,
    .depth_out);

// ==== test/probed_system_model.sv ====
// behavioural probed system: drives sample channels and clock qualifiers
// assumes the bench supplies its clock and asks for a hit pattern
`timescale 1ns/1ps
module probed_system_model (
    input wire logic clk_in,
    input wire logic hit_in,
    input wire logic [31:0] hit_value_in,
    input wire logic qual_ok_in,
    output logic [31:0] sample_out,
    output logic [3:0] qual_out
);
    logic [23:0] count_reg = 24'h0;
    initial sample_out = 32'h0;
    initial qual_out = 4'h0;
    // low byte stays zero so only a hit matches the byte pattern
    always @(posedge clk_in) begin
        count_reg <= #1 count_reg + 24'h1;
        sample_out <= #1 hit_in ? hit_value_in : {count_reg, 8'h00};
        qual_out <= #1 qual_ok_in ? 4'hF : 4'h0;
    end
endmodule : probed_system_model

// ==== test/testbench.sv ====
// self-checking bench of the state trigger sequencer
// assumes the probed-system model and the checker bind are compiled too
`timescale 1ns/1ps
module testbench
    import state_trigger_sequencer_pkg::*;
;
    logic clk_in = 1'b0, rst_n_in = 1'b0, cfg_we_in = 1'b0, arm_in = 1'b0;
    logic fast_mode_in = 1'b0, timing_mode_in = 1'b0, tags_en_in = 1'b0;
    logic all_pods_in = 1'b0, analyzer2_req_in = 1'b0, hit = 1'b0;
    logic qual_ok = 1'b1;
    logic [3:0] qual_sel_in = 4'h1;
    logic [8:0] cfg_addr_in = 9'h000;
    logic [31:0] cfg_data_in = 32'h0, mem_depth_in = 32'h4;
    logic [1:0] trig_pos_in = POS_END;
    logic [31:0] user_post_in = 32'h1;
    logic [31:0] sample_in, store_data_out, depth_out;
    logic [3:0] qual_in, level_out, flags_out;
    logic store_out, trigger_out, triggered_out, done_out, analyzer2_run_out;
    int fails = 0;
    int n_compared = 0;
    always #5 clk_in = ~clk_in;
    state_trigger_sequencer dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .sample_in(sample_in), .qual_in(qual_in), .qual_sel_in(qual_sel_in),
        .cfg_we_in(cfg_we_in), .cfg_addr_in(cfg_addr_in),
        .cfg_data_in(cfg_data_in), .fast_mode_in(fast_mode_in),
        .timing_mode_in(timing_mode_in), .arm_in(arm_in),
        .trig_pos_in(trig_pos_in), .user_post_in(user_post_in),
        .mem_depth_in(mem_depth_in), .tags_en_in(tags_en_in),
        .all_pods_in(all_pods_in), .analyzer2_req_in(analyzer2_req_in),
        .store_out(store_out), .store_data_out(store_data_out),
        .trigger_out(trigger_out), .triggered_out(triggered_out),
        .done_out(done_out), .level_out(level_out), .flags_out(flags_out),
        .analyzer2_run_out(analyzer2_run_out), .depth_out(depth_out));
    probed_system_model u_sys (.clk_in(clk_in), .hit_in(hit),
        .hit_value_in(32'h0000_00A5), .qual_ok_in(qual_ok),
        .sample_out(sample_in), .qual_out(qual_in));
    task automatic close_out;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : close_out
    task automatic tick;
        @(posedge clk_in);
        #1;
    endtask : tick
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got %0h exp %0h", $time, got, exp);
        end
    endtask : check
    task automatic cfg(input logic [8:0] a, input logic [31:0] d);
        cfg_we_in = 1'b1;
        cfg_addr_in = a;
        cfg_data_in = d;
        tick();
        cfg_we_in = 1'b0;
        tick();
    endtask : cfg
    task automatic arm;
        arm_in = 1'b1;
        tick();
        arm_in = 1'b0;
    endtask : arm
    // sel 0 waits for a level, sel 1 for the trigger pulse
    task automatic wait_on(input int sel, input logic [3:0] lvl);
        int i;
        for (i = 0; i < 200; i++) begin
            if (sel == 0 && level_out === lvl) break;
            if (sel == 1 && trigger_out === 1'b1) break;
            tick();
        end
        if (i == 200) begin
            fails++;
            $display("BAD t=%0t wait %0h level %0h", $time, sel, level_out);
            close_out();
        end
    endtask : wait_on
    task automatic s_reset;
        check({level_out, flags_out}, 32'h0);
        check({triggered_out, done_out, trigger_out}, 32'h0);
    endtask : s_reset
    task automatic s_sequence;
        cfg(9'h000, 32'h0000_00A5);
        cfg(9'h001, 32'h0000_00FF);
        cfg(9'h06D, 32'h8200_0011);
        cfg(9'h080, 32'h0000_0001);
        cfg(9'h081, 32'h0000_0001);
        cfg(9'h083, 32'h8000_0020);
        qual_ok = 1'b0;
        // let the stale qualifiers drain out of the pipeline first
        repeat (6) tick();
        arm();
        repeat (20) tick();
        check(level_out, 4'h0);
        qual_ok = 1'b1;
        wait_on(0, 4'h1);
        check(flags_out, 4'h4);
        repeat (20) tick();
        check(triggered_out, 1'b0);
        hit = 1'b1;
        tick();
        hit = 1'b0;
        wait_on(1, 4'h0);
        check(done_out, 1'b1);
    endtask : s_sequence
    // stores after trigger at depth 4: start 3, centre 2, end 0, user 1
    task automatic s_post_fill;
        int n_store;
        int n_trig;
        logic [7:0] post_n;
        post_n = {2'h1, 2'h0, 2'h2, 2'h3};
        cfg(9'h06D, 32'h8000_0020);
        for (int p = 0; p < 4; p++) begin
            n_store = 0;
            n_trig = 0;
            trig_pos_in = 2'(p);
            arm();
            wait_on(1, 4'h0);
            for (int i = 0; i < 50 && done_out !== 1'b1; i++) begin
                tick();
                n_store += int'(store_out === 1'b1);
                n_trig += int'(trigger_out === 1'b1);
            end
            check(32'(n_store), 32'(post_n[2*p+:2]));
            check(32'(n_trig), 32'h0);
            check(done_out, 1'b1);
        end
    endtask : s_post_fill
    task automatic s_fast_mode;
        fast_mode_in = 1'b1;
        cfg(9'h06D, 32'h0);
        cfg(9'h075, 32'h8000_0015);
        arm();
        repeat (20) tick();
        check(level_out, 4'h0);
        cfg(9'h071, 32'h8200_0013);
        wait_on(0, 4'h3);
        check(flags_out, 4'h0);
        cfg(9'h0AF, 32'h8000_0031);
        wait_on(1, 4'h0);
        check(level_out, 4'h3);
        fast_mode_in = 1'b0;
    endtask : s_fast_mode
    task automatic s_depth;
        logic [31:0] exp;
        mem_depth_in = 32'h0000_1000;
        analyzer2_req_in = 1'b1;
        for (int i = 0; i < 4; i++) begin
            {all_pods_in, tags_en_in} = 2'(i);
            {timing_mode_in, fast_mode_in} = 2'(i);
            tick();
            tick();
            exp = (i == 3) ? 32'h0000_0800 : 32'h0000_1000;
            check(depth_out, exp);
            check(analyzer2_run_out, 1'(i != 1));
        end
    endtask : s_depth
    initial begin
        repeat (6) @(posedge clk_in);
        #1;
        rst_n_in = 1'b1;
        s_reset();
        s_sequence();
        s_post_fill();
        s_fast_mode();
        s_depth();
        close_out();
    end
endmodule : testbench
